/* File: src/supply_fault_status_bank.sv */
// Supply and boost fault status bank with AXI4-Lite register access.
//
// Overview of operation
// - Configuration check error latches status bit 15 high; zero when no fault.
// - Missing boost sync clock latches status bit 13 high; zero otherwise.
// - Charge pump fault latches status bit 11 high; zero otherwise.
// - Missing charge pump capacitor latches status bit 9 high; zero otherwise.
// - Input over-current latches status bit 7 high; zero otherwise.
// - Logic supply undervoltage latches status bit 5 high; zero otherwise.
// - Input over-voltage latches status bit 3 high; zero otherwise.
// - Input undervoltage latches status bit 1 high; zero otherwise.
// - Writing one to status and its lower ack bit together clears the flag; irq falls once no supply or boost flag is left.
// - Supply fault register sits at index 0Eh and resets to zero.
// - Boost fault register sits at index 10h and resets to zero.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "fault_bank_map.svh"

module supply_fault_status_bank
    import fault_bank_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Supply fault sources, asynchronous levels
    input  wire logic              config_check_fault,
    input  wire logic              sync_clock_missing,
    input  wire logic              pump_fault,
    input  wire logic              pump_capacitor_missing,
    input  wire logic              input_overcurrent,
    input  wire logic              logic_supply_low,
    input  wire logic              input_overvoltage,
    input  wire logic              input_supply_low,
    // Boost fault sources, asynchronous levels, bit i reported as pair i at status bits 2i+1 and 2i
    input  wire logic [7:0]        boost_fault,
    // Interrupt request
    output logic                   irq,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic [2:0]        awprot,
    input  wire logic              awvalid,
    output logic                   awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic [2:0]        arprot,
    input  wire logic              arvalid,
    output logic                   arready,
    // AXI4-Lite read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    // ------------------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] supply_addr = ADDR_W'(`SUPPLY_FLAGS_IDX * 4);
    localparam logic [ADDR_W-1:0] boost_addr  = ADDR_W'(`BOOST_FLAGS_IDX * 4);
    localparam logic [ADDR_W-1:0] irq_addr    = ADDR_W'(`IRQ_CONTROL_IDX * 4);

    // ------------------------------------------------------------------------
    // Fault input synchronisation
    // ------------------------------------------------------------------------
    logic [7:0] supply_raw;
    logic [7:0] supply_seen;
    logic [7:0] boost_seen;

    assign supply_raw = {config_check_fault, sync_clock_missing, pump_fault,
                         pump_capacitor_missing, input_overcurrent, logic_supply_low,
                         input_overvoltage, input_supply_low};

    fault_sync #(.WIDTH(16)) u_sync
    (
        .clk       (clk),
        .rst       (rst),
        .level_in  ({supply_raw, boost_fault}),
        .level_out ({supply_seen, boost_seen})
    );

    // ------------------------------------------------------------------------
    // Bus handshake state
    // ------------------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_q;
    logic [15:0]       w_data_q;
    logic              aw_held;
    logic              w_held;
    logic              next_aw_held;
    logic              next_w_held;
    logic              next_bvalid;
    logic              next_rvalid;
    logic              aw_fire;
    logic              w_fire;
    logic              write_fire;
    logic              ar_fire;

    assign aw_fire      = awvalid & awready;
    assign w_fire       = wvalid & wready;
    assign ar_fire      = arvalid & arready;
    // Address and data are taken in either order; the write acts once both are held.
    assign write_fire   = aw_held & w_held & ~bvalid;
    assign next_aw_held = aw_held ? ~write_fire : aw_fire;
    assign next_w_held  = w_held ? ~write_fire : w_fire;
    assign next_bvalid  = write_fire | (bvalid & ~bready);
    assign next_rvalid  = ar_fire | (rvalid & ~rready);

    // ------------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------------
    logic wr_supply;
    logic wr_boost;
    logic wr_irq;
    logic wr_hit;

    assign wr_supply = aw_addr_q[ADDR_W-1:2] == supply_addr[ADDR_W-1:2];
    assign wr_boost  = aw_addr_q[ADDR_W-1:2] == boost_addr[ADDR_W-1:2];
    assign wr_irq    = aw_addr_q[ADDR_W-1:2] == irq_addr[ADDR_W-1:2];
    assign wr_hit    = wr_supply | wr_boost | wr_irq;

    // ------------------------------------------------------------------------
    // Fault flags
    // ------------------------------------------------------------------------
    logic [7:0] supply_flag;
    logic [7:0] boost_flag;
    logic [7:0] next_supply_flag;
    logic [7:0] next_boost_flag;
    logic [7:0] clr_supply;
    logic [7:0] clr_boost;
    flag_word_t supply_word;
    flag_word_t boost_word;

    // Byte enables are already folded into w_data_q when the data is taken.
    for (genvar i = 0; i < 8; i++)
    begin : g_pair
        assign clr_supply[i] = write_fire & wr_supply
                               & w_data_q[2*i+1] & w_data_q[2*i];
        assign clr_boost[i]  = write_fire & wr_boost
                               & w_data_q[2*i+1] & w_data_q[2*i];
        // A fault present in the clearing cycle wins over the clear.
        assign next_supply_flag[i] = supply_seen[i] | (supply_flag[i] & ~clr_supply[i]);
        assign next_boost_flag[i]  = boost_seen[i] | (boost_flag[i] & ~clr_boost[i]);
        // Ack bits act only in the write and read back as zero.
        assign supply_word[2*i+1]  = supply_flag[i];
        assign supply_word[2*i]    = 1'b0;
        assign boost_word[2*i+1]   = boost_flag[i];
        assign boost_word[2*i]     = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            supply_flag <= 8'h00;
            boost_flag  <= 8'h00;
        end
        else
        begin
            supply_flag <= next_supply_flag;
            boost_flag  <= next_boost_flag;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt control
    // ------------------------------------------------------------------------
    logic [1:0] irq_field;
    logic       irq_enabled;
    logic       any_flag;
    logic       wstrb_lo_q;

    assign irq_enabled = irq_field == `IRQ_ENABLE_CODE;
    assign any_flag    = |{supply_flag, boost_flag};

    always_ff @(posedge clk)
    begin
        if (rst)
            irq_field <= `IRQ_CONTROL_RESET;
        else if (write_fire & wr_irq & wstrb_lo_q)
            irq_field <= w_data_q[1:0];
    end

    // ------------------------------------------------------------------------
    // Bus registers
    // ------------------------------------------------------------------------
    logic       rd_supply;
    logic       rd_boost;
    logic       rd_irq;
    flag_word_t next_rdata;

    assign rd_supply  = araddr[ADDR_W-1:2] == supply_addr[ADDR_W-1:2];
    assign rd_boost   = araddr[ADDR_W-1:2] == boost_addr[ADDR_W-1:2];
    assign rd_irq     = araddr[ADDR_W-1:2] == irq_addr[ADDR_W-1:2];
    assign next_rdata = rd_supply ? supply_word :
                        rd_boost  ? boost_word  :
                        rd_irq    ? {14'h0000, irq_field} : 16'h0000;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held    <= 1'b0;
            w_held     <= 1'b0;
            aw_addr_q  <= '0;
            w_data_q   <= 16'h0000;
            wstrb_lo_q <= 1'b0;
            awready    <= 1'b0;
            wready     <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= resp_okay;
            arready    <= 1'b0;
            rvalid     <= 1'b0;
            rresp      <= resp_okay;
            rdata      <= 32'h0000_0000;
            irq        <= 1'b0;
        end
        else
        begin
            aw_held <= next_aw_held;
            w_held  <= next_w_held;
            awready <= ~next_aw_held & ~next_bvalid;
            wready  <= ~next_w_held & ~next_bvalid;
            arready <= ~next_rvalid;
            bvalid  <= next_bvalid;
            rvalid  <= next_rvalid;
            irq     <= irq_enabled & any_flag;
            if (aw_fire)
                aw_addr_q <= awaddr;
            if (w_fire)
            begin
                w_data_q   <= wdata[15:0] & {{8{wstrb[1]}}, {8{wstrb[0]}}};
                wstrb_lo_q <= wstrb[0];
            end
            if (write_fire)
                bresp <= wr_hit ? resp_okay : resp_slverr;
            if (ar_fire)
            begin
                rdata <= {16'h0000, next_rdata};
                rresp <= (rd_supply | rd_boost | rd_irq) ? resp_okay : resp_slverr;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    crc_latch_a: assert property (
        supply_seen[7] |=> supply_word[`CONFIG_CHECK_FAULT_FLAG_BIT])
        else $error("config check fault not latched");

    sync_latch_a: assert property (
        $rose(supply_seen[6]) |=> supply_word[`SYNC_CLOCK_MISSING_FLAG_BIT])
        else $error("sync clock fault not latched");

    pump_latch_a: assert property (
        supply_seen[5] |=> supply_word[`PUMP_FAULT_FLAG_BIT] && !supply_word[10])
        else $error("pump fault not latched");

    cap_latch_a: assert property (
        supply_seen[4] |=> supply_word[`PUMP_CAPACITOR_MISSING_FLAG_BIT])
        else $error("pump capacitor fault not latched");

    ocp_latch_a: assert property (
        supply_seen[3] |=> supply_flag[3] [*1] ##0 supply_word[`INPUT_OVERCURRENT_FLAG_BIT])
        else $error("over-current fault not latched");

    vdd_latch_a: assert property (
        supply_seen[2] |=> supply_word[`LOGIC_SUPPLY_LOW_FLAG_BIT])
        else $error("logic supply fault not latched");

    ovp_latch_a: assert property (
        supply_seen[1] |=> supply_word[`INPUT_OVERVOLTAGE_FLAG_BIT])
        else $error("over-voltage fault not latched");

    uvlo_latch_a: assert property (
        !supply_flag[0] && !supply_seen[0] |=> !supply_word[`INPUT_SUPPLY_LOW_FLAG_BIT])
        else $error("input low flag set without fault");

    pair_clear_a: assert property (
        clr_supply[0] && supply_seen == 8'h00 && boost_seen == 8'h00
        && supply_flag[7:1] == 7'h00 && boost_flag == 8'h00 |=> !supply_flag[0] ##1 !irq)
        else $error("paired write did not clear flag");

    reset_zero_a: assert property (disable iff (1'b0)
        rst |=> supply_flag == 8'h00 && boost_flag == 8'h00 && !irq)
        else $error("flags not zero after reset");

    supply_read_a: assert property (
        ar_fire && rd_supply |=> rvalid && rdata[15:0] == $past(supply_word))
        else $error("supply register read wrong");

    boost_read_a: assert property (
        ar_fire && rd_boost |=> rvalid && rdata[15:0] == $past(boost_word))
        else $error("boost register read wrong");

    half_write_a: assert property (
        write_fire && wr_supply && (w_data_q[1] ^ w_data_q[0]) && supply_flag[0]
        |=> supply_flag[0])
        else $error("single bit write cleared flag");

    flag_hold_a: assert property (
        boost_flag[2] && !clr_boost[2] |=> boost_flag[2])
        else $error("flag dropped without clear");

    write_answer_a: assert property (
        write_fire |=> bvalid)
        else $error("write response missing");

    clear_seen_c: cover property (clr_supply[7] ##1 !supply_flag[7]);
    irq_raise_c:  cover property (irq_enabled && $rose(irq));
    read_done_c:  cover property (ar_fire && rd_boost ##1 rvalid && rready);
    bad_write_c:  cover property (bvalid && bresp == resp_slverr);

endmodule

/* File: inc/fault_bank_map.svh */
// Register offsets, field positions, reset values and codes of the supply fault bank.
`ifndef FAULT_BANK_MAP_SVH
`define FAULT_BANK_MAP_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define SUPPLY_FLAGS_IDX      8'h0e
`define BOOST_FLAGS_IDX       8'h10
`define IRQ_CONTROL_IDX       8'h12

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SUPPLY_FLAGS_RESET    16'h0000
`define BOOST_FLAGS_RESET     16'h0000
`define IRQ_CONTROL_RESET     2'h0

// ----------------------------------------------------------------------------
// Field positions of the supply fault flags (status bit, ack is one lower)
// ----------------------------------------------------------------------------
`define CONFIG_CHECK_FAULT_FLAG_BIT       15
`define SYNC_CLOCK_MISSING_FLAG_BIT       13
`define PUMP_FAULT_FLAG_BIT               11
`define PUMP_CAPACITOR_MISSING_FLAG_BIT   9
`define INPUT_OVERCURRENT_FLAG_BIT        7
`define LOGIC_SUPPLY_LOW_FLAG_BIT         5
`define INPUT_OVERVOLTAGE_FLAG_BIT        3
`define INPUT_SUPPLY_LOW_FLAG_BIT         1

// ----------------------------------------------------------------------------
// Interrupt enable field codes
// ----------------------------------------------------------------------------
`define IRQ_ENABLE_CODE       2'h3
`define IRQ_DISABLE_CODE      2'h1

`endif

/* File: inc/fault_bank_pkg.sv */
// Types shared by the supply fault bank design files.
package fault_bank_pkg;

    typedef logic [15:0] flag_word_t;

    typedef enum logic [1:0]
    {
        resp_okay   = 2'b00,
        resp_slverr = 2'b10
    } axi_resp_t;

endpackage

/* File: src/fault_sync.sv */
// Two-flop synchroniser for a vector of asynchronous fault levels.
`timescale 1ns/1ps

module fault_sync
    import fault_bank_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fault levels
    input  wire logic [WIDTH-1:0] level_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage;

    // The first stage is read only by the second stage.
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                stage[i]     <= 1'b0;
                level_out[i] <= 1'b0;
            end
            else
            begin
                stage[i]     <= level_in[i];
                level_out[i] <= stage[i];
            end
        end
    end

endmodule

/* File: test/axi_host_model.sv */
// Behavioural AXI4-Lite host that plays the software side of the fault bank.
`timescale 1ns/1ps

module axi_host_model
(
    // Clock
    input  wire logic        clk,
    // Write channels
    output logic [7:0]       awaddr,
    output logic [2:0]       awprot,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // Read channels
    output logic [7:0]       araddr,
    output logic [2:0]       arprot,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    localparam int LIMIT = 100;

    // Byte enables of the next write; the bench narrows them for strobe tests.
    logic [3:0] strobe_sel = 4'hf;

    initial
    begin
        {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arprot, arvalid, rready} = '0;
    end

    // Address and data are offered together; each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] resp, output bit ok);
        ok = 1'b0;
        resp = 2'h0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= strobe_sel;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < LIMIT && !ok; n++)
        begin
            @(posedge clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                resp = bresp;
                ok = 1'b1;
                bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp, output bit ok);
        ok = 1'b0;
        d = '0;
        resp = 2'h0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < LIMIT && !ok; n++)
        begin
            @(posedge clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                d = rdata;
                resp = rresp;
                ok = 1'b1;
                rready <= 1'b0;
            end
        end
    endtask
endmodule

/* File: test/test_supply_fault_status_bank.sv */
// Self-checking testbench for the supply fault status bank.
`timescale 1ns/1ps
`include "fault_bank_map.svh"

module test_supply_fault_status_bank
    import fault_bank_pkg::*;
;
    localparam logic [7:0] SUP_A = 8'(`SUPPLY_FLAGS_IDX * 4);
    localparam logic [7:0] BST_A = 8'(`BOOST_FLAGS_IDX * 4);
    localparam logic [7:0] IRQ_A = 8'(`IRQ_CONTROL_IDX * 4);
    localparam logic [7:0] BAD_A = 8'h3c;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  sup = 8'h00;
    logic [7:0]  boost_fault = 8'h00;
    logic        irq, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [2:0]  awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          errors = 0;
    int          n_checks = 0;

    always #5 clk = ~clk;

    // Bit i of sup drives the source whose status sits at bit 2i+1.
    supply_fault_status_bank u_supply_fault_status_bank
    (
        .clk(clk), .rst(rst), .config_check_fault(sup[7]), .sync_clock_missing(sup[6]),
        .pump_fault(sup[5]), .pump_capacitor_missing(sup[4]), .input_overcurrent(sup[3]),
        .logic_supply_low(sup[2]), .input_overvoltage(sup[1]), .input_supply_low(sup[0]),
        .boost_fault(boost_fault), .irq(irq), .awaddr(awaddr), .awprot(awprot),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready)
    );

    axi_host_model host
    (
        .clk(clk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic stuck(input string what);
        errors++;
        $display("MISMATCH at %0t: %s never answered", $time, what);
        end_of_test();
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] resp;
        bit         ok;
        host.wr(a, d, resp, ok);
        if (!ok)
            stuck("write");
        chk(32'(resp), 32'(er), "write response");
    endtask

    task automatic r(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  resp;
        bit          ok;
        host.rd(a, d, resp, ok);
        if (!ok)
            stuck("read");
        chk(d, ed, "read data");
        chk(32'(resp), 32'(er), "read response");
    endtask

    // The fault is held well past the synchroniser and latch delay, then removed.
    task automatic pulse(input logic [7:0] s, input logic [7:0] b);
        @(posedge clk);
        sup <= s;
        boost_fault <= b;
        repeat (6) @(posedge clk);
        sup <= 8'h00;
        boost_fault <= 8'h00;
        repeat (4) @(posedge clk);
    endtask

    task automatic t_reset();
        chk(32'(irq), 32'h0, "irq after reset");
        r(SUP_A, 32'h0, resp_okay);
        r(BST_A, 32'h0, resp_okay);
        r(BAD_A, 32'h0, resp_slverr);
        w(BAD_A, 32'hffff, resp_slverr);
        r(SUP_A, 32'h0, resp_okay);
        $display("test reset done");
    endtask

    task automatic t_sources();
        logic [31:0] bit_s;
        for (int i = 0; i < 8; i++)
        begin
            bit_s = 32'h2 << (2 * i);
            pulse(8'h01 << i, 8'h00);
            r(SUP_A, bit_s, resp_okay);
            w(SUP_A, bit_s, resp_okay);
            r(SUP_A, bit_s, resp_okay);
            w(SUP_A, bit_s >> 1, resp_okay);
            r(SUP_A, bit_s, resp_okay);
            w(SUP_A, bit_s | (bit_s >> 1), resp_okay);
            r(SUP_A, 32'h0, resp_okay);
        end
        pulse(8'hff, 8'h00);
        r(SUP_A, 32'haaaa, resp_okay);
        w(SUP_A, 32'h0f0f, resp_okay);
        r(SUP_A, 32'ha0a0, resp_okay);
        w(SUP_A, 32'hffff, resp_okay);
        r(SUP_A, 32'h0, resp_okay);
        $display("test sources done");
    endtask

    task automatic t_irq();
        w(IRQ_A, 32'(`IRQ_ENABLE_CODE), resp_okay);
        pulse(8'h01, 8'h00);
        chk(32'(irq), 32'h1, "irq raised");
        w(IRQ_A, 32'(`IRQ_DISABLE_CODE), resp_okay);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "irq disabled");
        r(IRQ_A, 32'(`IRQ_DISABLE_CODE), resp_okay);
        w(IRQ_A, 32'h2, resp_okay);
        r(IRQ_A, 32'h2, resp_okay);
        chk(32'(irq), 32'h0, "irq off for other code");
        w(IRQ_A, 32'(`IRQ_ENABLE_CODE), resp_okay);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1, "irq enabled again");
        r(IRQ_A, 32'(`IRQ_ENABLE_CODE), resp_okay);
        w(SUP_A, 32'h1, resp_okay);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h1, "irq kept by lone ack");
        w(SUP_A, 32'h3, resp_okay);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0, "irq cleared");
        $display("test irq done");
    endtask

    task automatic t_boost();
        pulse(8'h00, 8'h81);
        r(BST_A, 32'h8002, resp_okay);
        r(SUP_A, 32'h0, resp_okay);
        w(BST_A, 32'hc000, resp_okay);
        r(BST_A, 32'h0002, resp_okay);
        w(BST_A, 32'h0003, resp_okay);
        r(BST_A, 32'h0, resp_okay);
        $display("test boost done");
    endtask

    // Reset in mid-run must drop latched flags, the irq field and the pin.
    task automatic t_midreset();
        pulse(8'h80, 8'h01);
        chk(32'(irq), 32'h1, "irq before reset");
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'(irq), 32'h0, "irq after mid reset");
        r(SUP_A, 32'h0, resp_okay);
        r(BST_A, 32'h0, resp_okay);
        r(IRQ_A, 32'(`IRQ_CONTROL_RESET), resp_okay);
        $display("test mid reset done");
    endtask

    // A byte that is not enabled carries zeros, so it can neither clear nor set a field.
    task automatic t_strobe();
        pulse(8'h01, 8'h00);
        host.strobe_sel = 4'h2;
        w(SUP_A, 32'h3, resp_okay);
        w(IRQ_A, 32'(`IRQ_ENABLE_CODE), resp_okay);
        host.strobe_sel = 4'hf;
        r(SUP_A, 32'h2, resp_okay);
        r(IRQ_A, 32'h0, resp_okay);
        w(SUP_A, 32'h3, resp_okay);
        r(SUP_A, 32'h0, resp_okay);
        $display("test strobe done");
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset();
        t_sources();
        t_irq();
        t_boost();
        t_midreset();
        t_strobe();
        end_of_test();
    end
endmodule
